// [dit_regs.svh]
// Register offsets, field positions, reset values and divider masks
`ifndef DIT_REGS_SVH
`define DIT_REGS_SVH

`define DIT_ADDR_PORT6_LATCH   16'hff06
`define DIT_ADDR_PORT6_DIR     16'hff26
`define DIT_ADDR_A_COUNTER     16'hff60
`define DIT_ADDR_A_COMPARE     16'hff62
`define DIT_ADDR_B_COUNTER     16'hff64
`define DIT_ADDR_A_CTRL        16'hff65
`define DIT_ADDR_B_COMPARE     16'hff66
`define DIT_ADDR_B_CTRL        16'hff69

`define DIT_PORT6_DIR_RESET    8'hff
`define DIT_PORT6_DIR_FIXED    6'h3f
`define DIT_PORT6_LATCH_RESET  2'h0
`define DIT_CTRL_RESET         8'h00
`define DIT_COMPARE_RESET      8'h00

`define DIT_CTRL_EN_BIT        7
`define DIT_A_CLKSEL_HI        4
`define DIT_A_CLKSEL_LO        3
`define DIT_A_MODE_BIT         1
`define DIT_B_CLKSEL_HI        5
`define DIT_B_CLKSEL_LO        3
`define DIT_B_MODE_HI          2
`define DIT_B_MODE_LO          1
`define DIT_B_OE_BIT           0
`define DIT_A_CTRL_MASK        8'h9a
`define DIT_B_CTRL_MASK        8'hbf

`define DIT_MASK_DIV1          8'h00
`define DIT_MASK_DIV2          8'h01
`define DIT_MASK_DIV4          8'h03
`define DIT_MASK_DIV8          8'h07
`define DIT_MASK_DIV16         8'h0f
`define DIT_MASK_DIV64         8'h3f
`define DIT_MASK_DIV256        8'hff

`endif

// [dit_pkg.sv]
// Types shared by the dual interval timer
package dit_pkg;

  typedef logic [7:0] dit_byte_t;

  typedef enum logic [2:0] {
    DIT_MODE_DISCRETE = 3'h0,
    DIT_MODE_PWM      = 3'h2,
    DIT_MODE_CARRIER  = 3'h3,
    DIT_MODE_CASCADE  = 3'h5
  } dit_mode_e;

  typedef enum logic [1:0] {
    DIT_ACLK_DIV64   = 2'h0,
    DIT_ACLK_DIV256  = 2'h1,
    DIT_ACLK_BMATCH  = 2'h2,
    DIT_ACLK_CARRIER = 2'h3
  } dit_aclk_e;

endpackage : dit_pkg

// [dit_timer.sv]
// Dual 8-bit interval and square-wave timer with port 6 direction control
//
// Behaviour
// - Direction bit 0 drives the low port pin; bit 1 leaves it input.
// - Direction register resets to all ones; upper six bits read one.
// - Discrete mode runs two independent 8-bit counters with own clocks.
// - Counter equal to compare clears to zero, keeps counting, interrupts.
// - Timer A clock: /64, /256, timer B match, timer B carrier.
// - Only timer B produces a square wave on a pin.
// - Timer B match inverts the wave, clears, continues, interrupts.
// - Clearing timer B count enable forces the wave low.
// - Enabling timer B output starts the wave at low level.
// - Cascade forms one 16-bit counter; timer B controls start, clear.
// - Timer B clock: /1, /4, /2, /4, /8, /16; other codes prohibited.
// - Count enable zero stops and clears; one starts counting.
// - Mode bits select discrete, cascade, carrier or PWM jointly; carrier and PWM codes count as discrete here.
// - Output enable zero gives port pin; one gives timer waveform.
`timescale 1ns/1ns
`include "dit_regs.svh"

module dit_timer
  import dit_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic [1:0]        port6_pin_in,
  output logic      [1:0]        port6_pin_out,
  output logic      [1:0]        port6_pin_oe,
  output logic                   timer_a_match_irq,
  output logic                   timer_b_match_irq
);

  // Only the low sixteen address bits are decoded
  if (ADDR_W < 16) begin : g_addr_check
    $error("dit_timer: ADDR_W must be at least 16");
  end

  dit_byte_t port6_direction_r;
  logic [1:0] port6_latch_r;
  dit_byte_t timer_a_ctrl_r;
  dit_byte_t timer_b_ctrl_r;
  dit_byte_t timer_a_compare_r;
  dit_byte_t timer_b_compare_r;
  dit_byte_t timer_a_counter_r;
  dit_byte_t timer_b_counter_r;
  dit_byte_t prescale_r;
  dit_byte_t reg_rdata_r;
  dit_byte_t rd_nxt;
  logic      timer_b_wave_output_r;
  logic      timer_b_oe_d_r;
  logic      a_irq_r;
  logic      b_irq_r;

  logic      timer_a_count_enable;
  logic      timer_b_count_enable;
  logic      timer_b_output_enable;
  logic [1:0] timer_a_clksel;
  logic [2:0] timer_b_clksel;
  dit_mode_e mode;
  logic      cascade;
  logic      a_run;
  logic      b_run;
  logic      a_tick;
  logic      b_tick;
  logic      b_match;
  logic      a_match;
  logic      b_carrier;
  logic      oe_rise;

  assign timer_a_count_enable  = timer_a_ctrl_r[`DIT_CTRL_EN_BIT];
  assign timer_b_count_enable  = timer_b_ctrl_r[`DIT_CTRL_EN_BIT];
  assign timer_b_output_enable = timer_b_ctrl_r[`DIT_B_OE_BIT];
  assign timer_a_clksel = timer_a_ctrl_r[`DIT_A_CLKSEL_HI:`DIT_A_CLKSEL_LO];
  assign timer_b_clksel = timer_b_ctrl_r[`DIT_B_CLKSEL_HI:`DIT_B_CLKSEL_LO];
  assign oe_rise = timer_b_output_enable & ~timer_b_oe_d_r;

  // Joint mode from both control registers; undefined codes act discrete
  always_comb begin
    case ({timer_a_ctrl_r[`DIT_A_MODE_BIT],
           timer_b_ctrl_r[`DIT_B_MODE_HI:`DIT_B_MODE_LO]})
      3'h5:    mode = DIT_MODE_CASCADE;
      3'h3:    mode = DIT_MODE_CARRIER;
      3'h2:    mode = DIT_MODE_PWM;
      default: mode = DIT_MODE_DISCRETE;
    endcase
  end

  assign cascade = (mode == DIT_MODE_CASCADE);
  assign b_run   = timer_b_count_enable;
  assign a_run   = cascade ? timer_b_count_enable : timer_a_count_enable;

  // Free-running prescaler for all divided count clocks
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prescale_r <= 8'h00;
    end else begin
      prescale_r <= prescale_r + 8'h01;
    end
  end

  // Timer B count clock enable pulse
  always_comb begin
    case (timer_b_clksel)
      3'h0:    b_tick = 1'b1;
      3'h1:    b_tick = (prescale_r & `DIT_MASK_DIV4) == `DIT_MASK_DIV4;
      3'h2:    b_tick = (prescale_r & `DIT_MASK_DIV2) == `DIT_MASK_DIV2;
      3'h3:    b_tick = (prescale_r & `DIT_MASK_DIV4) == `DIT_MASK_DIV4;
      3'h4:    b_tick = (prescale_r & `DIT_MASK_DIV8) == `DIT_MASK_DIV8;
      3'h5:    b_tick = (prescale_r & `DIT_MASK_DIV16) == `DIT_MASK_DIV16;
      default: b_tick = 1'b0;
    endcase
  end

  // Timer B match; in cascade the full 16-bit value is compared
  always_comb begin
    if (cascade) begin
      b_match = b_run & b_tick &
                ({timer_a_counter_r, timer_b_counter_r} ==
                 {timer_a_compare_r, timer_b_compare_r});
    end else begin
      b_match = b_run & b_tick & (timer_b_counter_r == timer_b_compare_r);
    end
  end

  // Carrier clock seen by timer A: rising edge of the timer B wave
  assign b_carrier = b_match & ~timer_b_wave_output_r;

  // Timer A count clock enable pulse
  always_comb begin
    if (cascade) begin
      a_tick = b_tick & (timer_b_counter_r == 8'hff);
    end else begin
      case (dit_aclk_e'(timer_a_clksel))
        DIT_ACLK_DIV64:
          a_tick = (prescale_r & `DIT_MASK_DIV64) == `DIT_MASK_DIV64;
        DIT_ACLK_DIV256:
          a_tick = (prescale_r & `DIT_MASK_DIV256) == `DIT_MASK_DIV256;
        DIT_ACLK_BMATCH:
          a_tick = b_match;
        default:
          a_tick = b_carrier;
      endcase
    end
  end

  assign a_match = ~cascade & a_run & a_tick &
                   (timer_a_counter_r == timer_a_compare_r);

  // Timer B counter
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer_b_counter_r <= 8'h00;
    end else if (!b_run) begin
      timer_b_counter_r <= 8'h00;
    end else if (b_match) begin
      timer_b_counter_r <= 8'h00;
    end else if (b_tick) begin
      timer_b_counter_r <= timer_b_counter_r + 8'h01;
    end
  end

  // Timer A counter; upper byte in cascade
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer_a_counter_r <= 8'h00;
    end else if (!a_run) begin
      timer_a_counter_r <= 8'h00;
    end else if ((cascade && b_match) || a_match) begin
      timer_a_counter_r <= 8'h00;
    end else if (a_tick) begin
      timer_a_counter_r <= timer_a_counter_r + 8'h01;
    end
  end

  // Interrupt pulses appear as the counter shows zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      a_irq_r <= 1'b0;
      b_irq_r <= 1'b0;
    end else begin
      a_irq_r <= a_match;
      b_irq_r <= b_match;
    end
  end

  assign timer_a_match_irq = a_irq_r;
  assign timer_b_match_irq = b_irq_r;

  // Square wave of timer B
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer_b_wave_output_r <= 1'b0;
      timer_b_oe_d_r        <= 1'b0;
    end else begin
      timer_b_oe_d_r <= timer_b_output_enable;
      if (!b_run) begin
        timer_b_wave_output_r <= 1'b0;
      end else if (oe_rise) begin
        timer_b_wave_output_r <= 1'b0;
      end else if (b_match) begin
        timer_b_wave_output_r <= ~timer_b_wave_output_r;
      end
    end
  end

  // Pins: only timer B reaches a pin; timer A has no waveform output
  assign port6_pin_oe  = ~port6_direction_r[1:0];
  assign port6_pin_out[0] = timer_b_output_enable ?
                            timer_b_wave_output_r : port6_latch_r[0];
  assign port6_pin_out[1] = port6_latch_r[1];

  // Register writes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port6_direction_r <= `DIT_PORT6_DIR_RESET;
      port6_latch_r     <= `DIT_PORT6_LATCH_RESET;
    end else if (reg_wr) begin
      if (reg_addr[15:0] == `DIT_ADDR_PORT6_DIR) begin
        port6_direction_r <= {`DIT_PORT6_DIR_FIXED, reg_wdata[1:0]};
      end else if (reg_addr[15:0] == `DIT_ADDR_PORT6_LATCH) begin
        port6_latch_r <= reg_wdata[1:0];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer_a_ctrl_r    <= `DIT_CTRL_RESET;
      timer_b_ctrl_r    <= `DIT_CTRL_RESET;
      timer_a_compare_r <= `DIT_COMPARE_RESET;
      timer_b_compare_r <= `DIT_COMPARE_RESET;
    end else if (reg_wr) begin
      if (reg_addr[15:0] == `DIT_ADDR_A_CTRL) begin
        timer_a_ctrl_r <= reg_wdata & `DIT_A_CTRL_MASK;
      end else if (reg_addr[15:0] == `DIT_ADDR_B_CTRL) begin
        timer_b_ctrl_r <= reg_wdata & `DIT_B_CTRL_MASK;
      end else if (reg_addr[15:0] == `DIT_ADDR_A_COMPARE) begin
        timer_a_compare_r <= reg_wdata;
      end else if (reg_addr[15:0] == `DIT_ADDR_B_COMPARE) begin
        timer_b_compare_r <= reg_wdata;
      end
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    rd_nxt = 8'h00;
    if (reg_addr[15:0] == `DIT_ADDR_PORT6_DIR) begin
      rd_nxt = port6_direction_r;
    end else if (reg_addr[15:0] == `DIT_ADDR_PORT6_LATCH) begin
      rd_nxt = {6'h00, (port6_latch_r & ~port6_direction_r[1:0]) |
                       (port6_pin_in & port6_direction_r[1:0])};
    end else if (reg_addr[15:0] == `DIT_ADDR_A_CTRL) begin
      rd_nxt = timer_a_ctrl_r;
    end else if (reg_addr[15:0] == `DIT_ADDR_B_CTRL) begin
      rd_nxt = timer_b_ctrl_r;
    end else if (reg_addr[15:0] == `DIT_ADDR_A_COMPARE) begin
      rd_nxt = timer_a_compare_r;
    end else if (reg_addr[15:0] == `DIT_ADDR_B_COMPARE) begin
      rd_nxt = timer_b_compare_r;
    end else if (reg_addr[15:0] == `DIT_ADDR_A_COUNTER) begin
      rd_nxt = timer_a_counter_r;
    end else if (reg_addr[15:0] == `DIT_ADDR_B_COUNTER) begin
      rd_nxt = timer_b_counter_r;
    end
  end

  // Read data stand for one cycle only
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_r <= rd_nxt;
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = reg_rdata_r;

  property p_dir_upper;
    @(posedge core_clk) disable iff (reset)
      reg_rd && reg_addr[15:0] == `DIT_ADDR_PORT6_DIR
      |=> reg_rdata[7:2] == 6'h3f;
  endproperty
  a_dir_upper: assert property (p_dir_upper)
    else $error("Direction upper bits did not read as one");

  property p_dir_pin;
    @(posedge core_clk) disable iff (reset)
      reg_wr && reg_addr[15:0] == `DIT_ADDR_PORT6_DIR
      |=> port6_pin_oe == ~$past(reg_wdata[1:0]);
  endproperty
  a_dir_pin: assert property (p_dir_pin)
    else $error("Pin driver does not follow direction bits");

  property p_b_match;
    @(posedge core_clk) disable iff (reset)
      b_match |=> timer_b_counter_r == 8'h00 && timer_b_match_irq;
  endproperty
  a_b_match: assert property (p_b_match)
    else $error("Timer B match did not clear and interrupt");

  property p_a_match;
    @(posedge core_clk) disable iff (reset)
      a_match |=> timer_a_counter_r == 8'h00 && timer_a_match_irq;
  endproperty
  a_a_match: assert property (p_a_match)
    else $error("Timer A match did not clear and interrupt");

  property p_stop_clear;
    @(posedge core_clk) disable iff (reset)
      !timer_b_count_enable |=> timer_b_counter_r == 8'h00;
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("Stopped timer B counter not zero");

  property p_wave_off;
    @(posedge core_clk) disable iff (reset)
      !timer_b_count_enable |=> !timer_b_wave_output_r;
  endproperty
  a_wave_off: assert property (p_wave_off)
    else $error("Wave not forced low while timer B stopped");

  property p_oe_start;
    @(posedge core_clk) disable iff (reset)
      $rose(timer_b_output_enable) |=> !timer_b_wave_output_r;
  endproperty
  a_oe_start: assert property (p_oe_start)
    else $error("Wave did not start low on output enable");

  property p_wave_toggle;
    @(posedge core_clk) disable iff (reset)
      b_match && !oe_rise
      |=> timer_b_wave_output_r != $past(timer_b_wave_output_r);
  endproperty
  a_wave_toggle: assert property (p_wave_toggle)
    else $error("Wave did not invert on timer B match");

  property p_a_chain;
    @(posedge core_clk) disable iff (reset)
      !cascade && timer_a_count_enable && timer_a_clksel == 2'h2 &&
      b_match && !a_match
      |=> timer_a_counter_r == $past(timer_a_counter_r) + 8'h01;
  endproperty
  a_a_chain: assert property (p_a_chain)
    else $error("Timer A did not advance on timer B match");

  property p_pin_wave;
    @(posedge core_clk) disable iff (reset)
      timer_b_output_enable && b_match && !oe_rise
      |=> port6_pin_out[0] == (timer_b_output_enable ?
          ~$past(timer_b_wave_output_r) : port6_latch_r[0]);
  endproperty
  a_pin_wave: assert property (p_pin_wave)
    else $error("Pin does not carry the timer B wave");

  property p_b_div2;
    @(posedge core_clk) disable iff (reset)
      timer_b_clksel == 3'h2 && $past(timer_b_clksel) == 3'h2
      |-> b_tick != $past(b_tick);
  endproperty
  a_b_div2: assert property (p_b_div2)
    else $error("Timer B half-rate clock wrong");

  property p_cascade_quiet;
    @(posedge core_clk) disable iff (reset)
      cascade && $past(cascade) |-> !timer_a_match_irq;
  endproperty
  a_cascade_quiet: assert property (p_cascade_quiet)
    else $error("Timer A interrupt raised in cascade mode");

endmodule : dit_timer

// [test_dit_timer.sv]
// Self-checking testbench for the dual interval timer
`timescale 1ns/1ns
`include "dit_regs.svh"

module test_dit_timer
  import dit_pkg::*;
;
  logic        core_clk;
  logic        reset;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [1:0]  port6_pin_in;
  logic [1:0]  port6_pin_out;
  logic [1:0]  port6_pin_oe;
  logic        timer_a_match_irq;
  logic        timer_b_match_irq;
  logic [31:0] cyc;
  logic [31:0] a_cnt;
  int          n_errors;
  int          num_checks;

  dit_timer #(.ADDR_W(16)) dut_u (
    .core_clk          (core_clk),
    .reset             (reset),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .port6_pin_in      (port6_pin_in),
    .port6_pin_out     (port6_pin_out),
    .port6_pin_oe      (port6_pin_oe),
    .timer_a_match_irq (timer_a_match_irq),
    .timer_b_match_irq (timer_b_match_irq)
  );

  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  // Free cycle count for interval measurement and timer A pulse tally for the cascade check
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (timer_a_match_irq === 1'b1) a_cnt <= a_cnt + 1;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic wait_irq(input logic sel_b, output logic [31:0] t);
    int k;
    t = '0;
    for (k = 0; k < 3000; k++) begin
      @(posedge core_clk);
      #1;
      if ((sel_b ? timer_b_match_irq : timer_a_match_irq) === 1'b1) begin
        t = cyc;
        return;
      end
    end
    chk("irq arrival", 32'h1, 32'h0);
  endtask : wait_irq

  task automatic measure(input logic sel_b, output logic [31:0] gap);
    logic [31:0] t1;
    logic [31:0] t2;
    wait_irq(sel_b, t1);
    wait_irq(sel_b, t2);
    gap = t2 - t1;
  endtask : measure

  function automatic logic [31:0] b_div(input logic [2:0] c);
    case (c)
      3'h0:    b_div = 32'h1;
      3'h2:    b_div = 32'h2;
      3'h4:    b_div = 32'h8;
      3'h5:    b_div = 32'h10;
      default: b_div = 32'h4;
    endcase
  endfunction : b_div

  function automatic logic [31:0] a_ivl(input logic [1:0] c,
                                        input logic [7:0] na,
                                        input logic [7:0] nb);
    case (c)
      DIT_ACLK_DIV64:  a_ivl = (na + 32'h1) * 32'h40;
      DIT_ACLK_DIV256: a_ivl = (na + 32'h1) * 32'h100;
      DIT_ACLK_BMATCH: a_ivl = (na + 32'h1) * (nb + 32'h1);
      default:         a_ivl = (na + 32'h1) * (nb + 32'h1) * 32'h2;
    endcase
  endfunction : a_ivl

  task automatic wrap_up();
    $display("checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #(40 * 40000);
    n_errors++;
    wrap_up();
  end

  initial begin
    logic [7:0]  d;
    logic [7:0]  w;
    logic [7:0]  cmp;
    logic [7:0]  na;
    logic [2:0]  code;
    logic [31:0] gap;
    logic [31:0] a0;
    int          i;
    reset = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    port6_pin_in = 2'h0;
    cyc = '0;
    a_cnt = '0;
    void'($urandom(32'hbadcc42c));
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    port6_pin_in <= 2'($urandom);
    rd(`DIT_ADDR_PORT6_DIR, d);
    chk("dir reset", 32'hff, d);
    chk("oe reset", 32'h0, port6_pin_oe);
    rd(`DIT_ADDR_PORT6_LATCH, d);
    chk("pin read", port6_pin_in, d & 8'h03);
    rd(16'hff27, d);
    chk("unmapped read", 32'h0, d);
    for (i = 0; i < 5; i++) begin
      w = (i == 4) ? 8'h00 : 8'($urandom);
      wr(`DIT_ADDR_PORT6_DIR, w);
      chk("pin oe", 2'(~w[1:0]), port6_pin_oe);
      rd(`DIT_ADDR_PORT6_DIR, d);
      chk("dir read", {6'h3f, w[1:0]}, d);
    end
    // Timer B clock codes 0 to 5, plus compare extremes at full rate
    for (i = 0; i < 8; i++) begin
      code = (i < 6) ? 3'(i) : 3'h0;
      cmp = (i == 6) ? 8'h00 : (i == 7) ? 8'hff : 8'($urandom_range(0, 15));
      wr(`DIT_ADDR_B_CTRL, 8'h00);
      wr(`DIT_ADDR_B_COMPARE, cmp);
      wr(`DIT_ADDR_B_CTRL, {2'b00, code, 3'b000});
      wr(`DIT_ADDR_B_CTRL, {2'b10, code, 3'b000});
      measure(1'b1, gap);
      chk("b interval", (cmp + 32'h1) * b_div(code), gap);
    end
    // Timer A every clock code; timer B is its source for codes 2 and 3
    wr(`DIT_ADDR_B_CTRL, 8'h00);
    wr(`DIT_ADDR_B_COMPARE, 8'h02);
    wr(`DIT_ADDR_B_CTRL, 8'h81);
    for (i = 0; i < 4; i++) begin
      na = 8'($urandom_range(0, 3));
      wr(`DIT_ADDR_A_CTRL, 8'h00);
      wr(`DIT_ADDR_A_COMPARE, na);
      wr(`DIT_ADDR_A_CTRL, {3'b000, 2'(i), 3'b000});
      wr(`DIT_ADDR_A_CTRL, {3'b100, 2'(i), 3'b000});
      measure(1'b0, gap);
      chk("a interval", a_ivl(2'(i), na, 8'h02), gap);
    end
    wr(`DIT_ADDR_A_CTRL, 8'h00);
    // Square wave on the shared pin
    wr(`DIT_ADDR_PORT6_DIR, 8'hfe);
    wr(`DIT_ADDR_PORT6_LATCH, 8'h00);
    wr(`DIT_ADDR_B_CTRL, 8'h00);
    wr(`DIT_ADDR_B_CTRL, 8'h01);
    cmp = 8'($urandom_range(1, 9));
    wr(`DIT_ADDR_B_COMPARE, cmp);
    wr(`DIT_ADDR_B_CTRL, 8'h81);
    chk("wave start", 32'h0, port6_pin_out[0]);
    wait_irq(1'b1, gap);
    chk("wave first", 32'h1, port6_pin_out[0]);
    wait_irq(1'b1, gap);
    chk("wave second", 32'h0, port6_pin_out[0]);
    wait_irq(1'b1, gap);
    wr(`DIT_ADDR_B_CTRL, 8'h01);
    @(posedge core_clk);
    #1;
    chk("wave stop", 32'h0, port6_pin_out[0]);
    wr(`DIT_ADDR_B_COUNTER, 8'h55);
    rd(`DIT_ADDR_B_COUNTER, d);
    chk("b cleared", 32'h0, d);
    wr(`DIT_ADDR_B_CTRL, 8'h00);
    wr(`DIT_ADDR_PORT6_LATCH, 8'h03);
    chk("port pin", 32'h3, port6_pin_out);
    // Cascade: sixteen bit interval, no timer A pulses even if A enabled
    wr(`DIT_ADDR_B_CTRL, 8'h02);
    wr(`DIT_ADDR_A_CTRL, 8'h82);
    wr(`DIT_ADDR_A_COMPARE, 8'h01);
    wr(`DIT_ADDR_B_COMPARE, 8'h02);
    a0 = a_cnt;
    wr(`DIT_ADDR_B_CTRL, 8'h82);
    measure(1'b1, gap);
    chk("cascade interval", 32'd259, gap);
    chk("cascade a quiet", a0, a_cnt);
    wr(`DIT_ADDR_B_CTRL, 8'h00);
    wrap_up();
  end
endmodule : test_dit_timer
